// File: design/lls_map.svh
`ifndef LLS_MAP_SVH
`define LLS_MAP_SVH
// ****************************************
// register map
// ****************************************
`define LLS_SEL_CTRL 12'h000
`define LLS_SEL_STAT 12'h004
`define LLS_SEL_OUT 12'h008
`define LLS_TBL_CFG 8'h00
`define LLS_TBL_OUT 8'h04
`define LLS_TBL_RANGE 8'h08
`define LLS_TBL_XPAGE 2'h1
`define LLS_TBL_YPAGE 2'h2
// ****************************************
// field positions
// ****************************************
`define LLS_CFG_AXIS 0
`define LLS_CFG_AUTO 1
`define LLS_CFG_SRC_LO 4
`define LLS_ENT_LOP_LO 4
`define LLS_CND_A1_LO 4
`define LLS_CND_A2_LO 8
`define LLS_Y_TYPE_LO 16
// ****************************************
// codes
// ****************************************
`define LLS_SEG_IGNORE 2'h0
`define LLS_SEG_RAMP 2'h1
`define LLS_SEG_JUMP 2'h2
`define LLS_AXIS_TIME 1'h1
`define LLS_OP_EQ 3'h0
`define LLS_OP_NE 3'h1
`define LLS_OP_GT 3'h2
`define LLS_OP_GE 3'h3
`define LLS_OP_LT 3'h4
`define LLS_OP_LE 3'h5
`define LLS_LOP_ALWAYS 3'h0
`define LLS_LOP_AND 3'h1
`define LLS_LOP_OR 3'h2
`define LLS_LOP_ANDOR 3'h3
`define LLS_LOP_ORAND 3'h4
// ****************************************
// limits and timing
// ****************************************
`define LLS_XMIN_DEF 16'sh0000
`define LLS_XMAX_DEF 16'sh03E8
`define LLS_CLK_PERIOD_NS 10
`define LLS_MS_NS 1000000
`define LLS_MS_CYCLES (`LLS_MS_NS / `LLS_CLK_PERIOD_NS)
`endif

// File: design/lls_pkg.sv
package lls_pkg;
    typedef logic signed [15:0] lls_val_t;
    typedef logic [1:0] lls_seg_t;
    typedef logic [2:0] lls_op_t;
    typedef logic [3:0] lls_arg_t;
endpackage : lls_pkg

// File: design/lls_top.sv
// Operation
// - each table holds eleven points X0..X10
// - axis type selects data or time
// - segment codes ignore ramp jump
// - ramp interpolates linearly between bounding points
// - jump yields this point's Y
// - first point always jump, not writable
// - ignore drops that point and later ones
// - autocycle restarts time profile while enabled
// - X clamped to source range or 0..1000
// - X values kept non-decreasing
// - output range from active Y values
// - selector drives sel_out only when enabled; reset off
// - three entries, table number, three conditions
// - comparison codes equal through less-equal
// - unused argument reads as zero
// - five combine codes for conditions
// - first true entry wins
// - none true falls back to entry one
// - output equals selected table output
`timescale 1ns/100ps
`include "lls_map.svh"
module lls_top #(
    parameter int NSRC = 8,
    parameter int MS_CYCLES = `LLS_MS_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hreadyin,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // signal sources
    input wire logic [NSRC*16-1:0] src_value,
    input wire logic [NSRC-1:0] src_ranged,
    input wire logic [NSRC*16-1:0] src_min,
    input wire logic [NSRC*16-1:0] src_max,
    // results
    output logic [15:0] sel_out,
    output logic sel_active,
    output logic [47:0] table_out
);
    localparam int NT = 3;
    localparam int NP = 11;
    localparam int CW = $clog2(MS_CYCLES);

    // ****************************************
    // shared helpers
    // ****************************************
    function automatic lls_pkg::lls_val_t srcv(input logic [NSRC*16-1:0] v, input int i);
        srcv = v[i*16 +: 16];
    endfunction : srcv

    // argument code 0 means unused and reads as zero
    function automatic lls_pkg::lls_val_t argv(input logic [NSRC*16-1:0] v, input lls_pkg::lls_arg_t a);
        argv = 16'sh0000;
        if (a != 4'h0 && int'(a) <= NSRC) begin
            argv = v[(int'(a) - 1)*16 +: 16];
        end
    endfunction : argv

    function automatic logic cmp(input lls_pkg::lls_op_t op, input lls_pkg::lls_val_t a,
                                 input lls_pkg::lls_val_t b);
        case (op)
            `LLS_OP_EQ: cmp = (a == b);
            `LLS_OP_NE: cmp = (a != b);
            `LLS_OP_GT: cmp = (a > b);
            `LLS_OP_GE: cmp = (a >= b);
            `LLS_OP_LT: cmp = (a < b);
            `LLS_OP_LE: cmp = (a <= b);
            default: cmp = 1'b0;
        endcase
    endfunction : cmp

    // ****************************************
    // ahb-lite slave
    // ****************************************
    logic [11:0] addr_q;
    logic hit_q;
    logic wr_q;
    logic hreadyout_q;
    logic [31:0] hrdata_q;
    logic [31:0] rdata;
    logic acc;
    logic we;

    assign acc = hsel && htrans[1] && hreadyin;
    assign we = wr_q && hit_q;
    assign hreadyout = hreadyout_q;
    assign hrdata = hrdata_q;

    // reads take one wait state so that hrdata comes from a flop
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            addr_q <= 12'h000;
            hit_q <= 1'b0;
            wr_q <= 1'b0;
            hreadyout_q <= 1'b1;
            hrdata_q <= 32'h0000_0000;
        end else if (hreadyout_q) begin
            wr_q <= acc && hwrite;
            hreadyout_q <= !(acc && !hwrite);
            if (acc) begin
                addr_q <= haddr[11:0];
                hit_q <= (haddr[31:12] == 20'h00000);
            end
        end else begin
            hreadyout_q <= 1'b1;
            hrdata_q <= rdata;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // ****************************************
    // configuration storage
    // ****************************************
    logic sel_en_q;
    logic [1:0] ent_tnum_q [NT];
    lls_pkg::lls_op_t ent_lop_q [NT];
    lls_pkg::lls_op_t cnd_op_q [NT][3];
    lls_pkg::lls_arg_t cnd_a1_q [NT][3];
    lls_pkg::lls_arg_t cnd_a2_q [NT][3];
    logic ent_hit;
    logic [1:0] ent_e;
    logic [1:0] ent_w;

    assign ent_hit = hit_q && addr_q[11:6] == 6'h00 && addr_q[5:4] != 2'h0;
    assign ent_e = addr_q[5:4] - 2'h1;
    assign ent_w = addr_q[3:2];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sel_en_q <= 1'b0;
        end else if (we && addr_q == `LLS_SEL_CTRL) begin
            sel_en_q <= hwdata[0];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int e = 0; e < NT; e++) begin
                ent_tnum_q[e] <= 2'h1;
                ent_lop_q[e] <= `LLS_LOP_ALWAYS;
                for (int c = 0; c < 3; c++) begin
                    cnd_op_q[e][c] <= `LLS_OP_EQ;
                    cnd_a1_q[e][c] <= 4'h0;
                    cnd_a2_q[e][c] <= 4'h0;
                end
            end
        end else if (we && ent_hit) begin
            if (ent_w == 2'h0) begin
                ent_tnum_q[ent_e] <= hwdata[1:0];
                ent_lop_q[ent_e] <= hwdata[`LLS_ENT_LOP_LO +: 3];
            end else begin
                cnd_op_q[ent_e][ent_w - 2'h1] <= hwdata[2:0];
                cnd_a1_q[ent_e][ent_w - 2'h1] <= hwdata[`LLS_CND_A1_LO +: 4];
                cnd_a2_q[ent_e][ent_w - 2'h1] <= hwdata[`LLS_CND_A2_LO +: 4];
            end
        end
    end

    // ****************************************
    // lookup tables
    // ****************************************
    lls_pkg::lls_val_t px_q [NT][NP];
    lls_pkg::lls_val_t py_q [NT][NP];
    lls_pkg::lls_seg_t pt_q [NT][NP];
    logic tcfg_axis_q [NT];
    logic tcfg_auto_q [NT];
    logic [3:0] tcfg_src_q [NT];
    lls_pkg::lls_val_t tval [NT];
    lls_pkg::lls_val_t tmin [NT];
    lls_pkg::lls_val_t tmax [NT];
    logic [15:0] elapsed_q [NT];
    logic [CW-1:0] ms_cnt_q;
    logic ms_tick;
    logic [NT-1:0] order_ok;
    lls_pkg::lls_val_t tout_q [NT];

    // one shared millisecond prescaler for all time-mode tables
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ms_cnt_q <= '0;
        end else if (ms_tick) begin
            ms_cnt_q <= '0;
        end else begin
            ms_cnt_q <= ms_cnt_q + 1'b1;
        end
    end
    assign ms_tick = (ms_cnt_q == CW'(MS_CYCLES - 1));

    for (genvar t = 0; t < NT; t++) begin : g_tbl
        logic thit;
        logic [3:0] pidx;
        lls_pkg::lls_val_t xin;
        lls_pkg::lls_val_t lo;
        lls_pkg::lls_val_t hi;
        lls_pkg::lls_val_t xlast;
        lls_pkg::lls_val_t sv;
        int sidx;

        assign thit = hit_q && addr_q[11:8] == 4'(t + 1);
        assign pidx = addr_q[5:2];
        assign sidx = int'(tcfg_src_q[t]) < NSRC ? int'(tcfg_src_q[t]) : 0;
        assign sv = srcv(src_value, sidx);

        // write bounds: source range, then neighbours keep the axis rising
        always_comb begin
            lo = src_ranged[sidx] ? srcv(src_min, sidx) : `LLS_XMIN_DEF;
            hi = src_ranged[sidx] ? srcv(src_max, sidx) : `LLS_XMAX_DEF;
            if (pidx != 4'h0 && pidx <= 4'hA && px_q[t][pidx - 4'h1] > lo) begin
                lo = px_q[t][pidx - 4'h1];
            end
            if (pidx < 4'hA && px_q[t][pidx + 4'h1] < hi) begin
                hi = px_q[t][pidx + 4'h1];
            end
        end

        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                tcfg_axis_q[t] <= 1'b0;
                tcfg_auto_q[t] <= 1'b0;
                tcfg_src_q[t] <= 4'h0;
                for (int n = 0; n < NP; n++) begin
                    px_q[t][n] <= 16'sh0000;
                    py_q[t][n] <= 16'sh0000;
                    pt_q[t][n] <= (n == 0) ? `LLS_SEG_JUMP : `LLS_SEG_IGNORE;
                end
            end else if (we && thit) begin
                if (addr_q[7:0] == `LLS_TBL_CFG) begin
                    tcfg_axis_q[t] <= hwdata[`LLS_CFG_AXIS];
                    tcfg_auto_q[t] <= hwdata[`LLS_CFG_AUTO];
                    tcfg_src_q[t] <= hwdata[`LLS_CFG_SRC_LO +: 4];
                end else if (addr_q[7:6] == `LLS_TBL_XPAGE && pidx <= 4'hA) begin
                    if ($signed(hwdata[15:0]) < lo) begin
                        px_q[t][pidx] <= lo;
                    end else if ($signed(hwdata[15:0]) > hi && hi >= lo) begin
                        px_q[t][pidx] <= hi;
                    end else begin
                        px_q[t][pidx] <= hwdata[15:0];
                    end
                end else if (addr_q[7:6] == `LLS_TBL_YPAGE && pidx <= 4'hA) begin
                    py_q[t][pidx] <= hwdata[15:0];
                    if (pidx != 4'h0 && hwdata[`LLS_Y_TYPE_LO +: 2] <= `LLS_SEG_JUMP) begin
                        pt_q[t][pidx] <= hwdata[`LLS_Y_TYPE_LO +: 2];
                    end
                end
            end
        end

        // elapsed time runs only while the source enables it
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                elapsed_q[t] <= 16'h0000;
            end else if (tcfg_axis_q[t] != `LLS_AXIS_TIME || sv == 16'sh0000) begin
                elapsed_q[t] <= 16'h0000;
            end else if (ms_tick) begin
                if ($signed(elapsed_q[t]) >= xlast) begin
                    elapsed_q[t] <= tcfg_auto_q[t] ? 16'h0000 : elapsed_q[t];
                end else begin
                    elapsed_q[t] <= elapsed_q[t] + 16'h0001;
                end
            end
        end

        assign xin = (tcfg_axis_q[t] == `LLS_AXIS_TIME) ? $signed(elapsed_q[t]) : sv;

        // segment search; the first ignored point ends the table
        always_comb begin
            logic act;
            logic found;
            logic [3:0] ia;
            logic [3:0] ib;
            lls_pkg::lls_seg_t seg;
            logic signed [16:0] dy;
            logic signed [16:0] dx;
            logic signed [16:0] dxi;
            logic signed [33:0] prod;
            logic signed [33:0] quo;
            act = 1'b1;
            found = (xin <= px_q[t][0]);
            ia = 4'h0;
            ib = 4'h0;
            seg = `LLS_SEG_JUMP;
            xlast = px_q[t][0];
            tmin[t] = py_q[t][0];
            tmax[t] = py_q[t][0];
            for (int n = 1; n < NP; n++) begin
                if (pt_q[t][n] == `LLS_SEG_IGNORE) begin
                    act = 1'b0;
                end
                if (act) begin
                    xlast = px_q[t][n];
                    if (py_q[t][n] < tmin[t]) tmin[t] = py_q[t][n];
                    if (py_q[t][n] > tmax[t]) tmax[t] = py_q[t][n];
                    if (!found) begin
                        ib = 4'(n);
                        if (xin <= px_q[t][n]) begin
                            found = 1'b1;
                            ia = 4'(n - 1);
                            seg = pt_q[t][n];
                        end
                    end
                end
            end
            dy = 17'(py_q[t][ib]) - 17'(py_q[t][ia]);
            dx = 17'(px_q[t][ib]) - 17'(px_q[t][ia]);
            dxi = 17'(xin) - 17'(px_q[t][ia]);
            prod = 34'(dy) * 34'(dxi);
            quo = (dx == 17'sh00000) ? 34'sh0 : prod / 34'(dx);
            if (seg == `LLS_SEG_RAMP && dx != 17'sh00000) begin
                tval[t] = 16'(34'(py_q[t][ia]) + quo);
            end else begin
                tval[t] = py_q[t][ib];
            end
        end

        always_comb begin
            order_ok[t] = 1'b1;
            for (int n = 1; n < NP; n++) begin
                if (px_q[t][n] < px_q[t][n - 1]) order_ok[t] = 1'b0;
            end
        end

        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                tout_q[t] <= 16'sh0000;
            end else begin
                tout_q[t] <= tval[t];
            end
        end
        assign table_out[t*16 +: 16] = tout_q[t];
    end

    // ****************************************
    // selector
    // ****************************************
    logic [NT-1:0] ent_ok;
    logic [1:0] sel_e;
    logic [1:0] sel_t;
    logic [1:0] sel_e_q;
    lls_pkg::lls_val_t sel_out_q;

    always_comb begin
        logic [2:0] c;
        c = 3'h0;
        for (int e = 0; e < NT; e++) begin
            for (int k = 0; k < 3; k++) begin
                c[k] = cmp(cnd_op_q[e][k], argv(src_value, cnd_a1_q[e][k]), argv(src_value, cnd_a2_q[e][k]));
            end
            case (ent_lop_q[e])
                `LLS_LOP_ALWAYS: ent_ok[e] = 1'b1;
                `LLS_LOP_AND: ent_ok[e] = c[0] && c[1] && c[2];
                `LLS_LOP_OR: ent_ok[e] = c[0] || c[1] || c[2];
                `LLS_LOP_ANDOR: ent_ok[e] = (c[0] && c[1]) || c[2];
                `LLS_LOP_ORAND: ent_ok[e] = (c[0] || c[1]) && c[2];
                default: ent_ok[e] = 1'b0;
            endcase
        end
        sel_e = 2'h0;
        for (int e = NT - 1; e >= 0; e--) begin
            if (ent_ok[e]) sel_e = 2'(e);
        end
        // table numbers count from one; zero falls back to table one
        sel_t = (ent_tnum_q[sel_e] == 2'h0) ? 2'h0 : ent_tnum_q[sel_e] - 2'h1;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sel_e_q <= 2'h0;
            sel_out_q <= 16'sh0000;
            sel_active <= 1'b0;
        end else begin
            sel_e_q <= sel_e;
            sel_active <= sel_en_q;
            sel_out_q <= sel_en_q ? tval[sel_t] : 16'sh0000;
        end
    end
    assign sel_out = sel_out_q;

    // ****************************************
    // read mux
    // ****************************************
    always_comb begin
        logic [1:0] t;
        t = addr_q[9:8] - 2'h1;
        rdata = 32'h0000_0000;
        if (!hit_q) begin
            rdata = 32'h0000_0000;
        end else if (addr_q == `LLS_SEL_CTRL) begin
            rdata = {31'h0, sel_en_q};
        end else if (addr_q == `LLS_SEL_STAT) begin
            rdata = {30'h0, sel_e_q};
        end else if (addr_q == `LLS_SEL_OUT) begin
            rdata = {{16{sel_out_q[15]}}, sel_out_q};
        end else if (ent_hit) begin
            rdata = (ent_w == 2'h0) ? {25'h0, ent_lop_q[ent_e], 2'h0, ent_tnum_q[ent_e]}
                  : {20'h0, cnd_a2_q[ent_e][ent_w - 2'h1], cnd_a1_q[ent_e][ent_w - 2'h1],
                     1'b0, cnd_op_q[ent_e][ent_w - 2'h1]};
        end else if (addr_q[11:10] == 2'h0 && addr_q[9:8] != 2'h0) begin
            if (addr_q[7:0] == `LLS_TBL_CFG) begin
                rdata = {24'h0, tcfg_src_q[t], 2'h0, tcfg_auto_q[t], tcfg_axis_q[t]};
            end else if (addr_q[7:0] == `LLS_TBL_OUT) begin
                rdata = {{16{tout_q[t][15]}}, tout_q[t]};
            end else if (addr_q[7:0] == `LLS_TBL_RANGE) begin
                rdata = {tmax[t], tmin[t]};
            end else if (addr_q[7:6] == `LLS_TBL_XPAGE && addr_q[5:2] <= 4'hA) begin
                rdata = {{16{px_q[t][addr_q[5:2]][15]}}, px_q[t][addr_q[5:2]]};
            end else if (addr_q[7:6] == `LLS_TBL_YPAGE && addr_q[5:2] <= 4'hA) begin
                rdata = {14'h0, pt_q[t][addr_q[5:2]], py_q[t][addr_q[5:2]]};
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_sel_disabled_zero: assert property (!sel_en_q |=> sel_out_q == 16'sh0000 && !sel_active)
        else $error("selector output not zero while disabled");
    a_sel_fallback_first: assert property (ent_ok == 3'b000 |=> sel_e_q == 2'h0)
        else $error("no true entry but entry one not chosen");
    a_sel_priority_first: assert property (ent_ok[0] |=> sel_e_q == 2'h0)
        else $error("entry one true but not chosen");
    // the registered output lags one edge, so the selection must hold across that edge
    a_sel_follows_table: assert property (sel_en_q ##1 sel_en_q && $stable(sel_t)
        |-> sel_out_q == tout_q[sel_t])
        else $error("selector output differs from selected table");
    a_point0_jump: assert property (pt_q[0][0] == `LLS_SEG_JUMP && pt_q[2][0] == `LLS_SEG_JUMP)
        else $error("first point lost its jump type");
    a_x_rising: assert property (order_ok == 3'b111)
        else $error("x axis not rising");
    a_range_order: assert property (tmin[0] <= tmax[0] && tmin[0] <= py_q[0][0] && tmax[0] >= py_q[0][0])
        else $error("output range does not hold point zero");
    a_ignore_tail: assert property (pt_q[1][1] == `LLS_SEG_IGNORE |=> tout_q[1] == $past(py_q[1][0]))
        else $error("ignored tail still used");
    a_time_hold_zero: assert property (tcfg_axis_q[2] && g_tbl[2].sv == 16'sh0000
        |=> elapsed_q[2] == 16'h0000)
        else $error("elapsed time runs without enable");
    a_read_wait: assert property (hreadyout_q && acc && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read answer not on second edge");

    c_entry_two: cover property (sel_en_q && sel_e_q == 2'h1);
    c_entry_three: cover property (sel_en_q && sel_e_q == 2'h2);
    c_auto_wrap: cover property (tcfg_auto_q[2] && elapsed_q[2] != 16'h0000 ##1 elapsed_q[2] == 16'h0000);
endmodule : lls_top

// File: test/lls_src_model.sv
`timescale 1ns/100ps
// ****
// source blocks feeding the evaluator
// ****
module lls_src_model (
    // bench control
    input wire logic clk,
    input wire logic [2:0] set_idx,
    input wire logic [15:0] set_val,
    input wire logic set_stb,
    // source outputs
    output logic [127:0] src_value,
    output logic [7:0] src_ranged,
    output logic [127:0] src_min,
    output logic [127:0] src_max
);
    // a source holds its last value, like a real block output
    initial src_value = '0;
    always @(posedge clk) begin
        if (set_stb) src_value[set_idx*16+:16] <= set_val;
    end
    // only source 7 brings its own span; the others use the default one
    assign src_ranged = 8'h80;
    assign src_min = {16'hFF9C, 112'h0};
    assign src_max = {16'h01F4, 112'h0};
endmodule : lls_src_model

// File: test/tb_lookup_table_logic_selector.sv
`timescale 1ns/100ps
module tb_lookup_table_logic_selector;
    // ****
    // signals
    // ****
    logic clk, sys_rst, hsel, hwrite, hreadyout, hresp, rdy_s, set_stb, sel_active;
    logic [31:0] haddr, hwdata, hrdata, rd_s, q;
    logic [1:0] htrans;
    logic [2:0] set_idx;
    logic [15:0] set_val, sel_out;
    logic [47:0] table_out;
    logic [127:0] src_value, src_min, src_max;
    logic [7:0] src_ranged;
    int fails, checks_done, cycles;
    lls_src_model i_src (.clk(clk), .set_idx(set_idx), .set_val(set_val), .set_stb(set_stb),
        .src_value(src_value), .src_ranged(src_ranged), .src_min(src_min), .src_max(src_max));
    lls_top #(.MS_CYCLES(10)) i_dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hreadyin(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .src_value(src_value),
        .src_ranged(src_ranged), .src_min(src_min), .src_max(src_max), .sel_out(sel_out),
        .sel_active(sel_active), .table_out(table_out));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // bus lines as they stood just before the next rising edge
    always @(negedge clk) begin
        rdy_s = hreadyout;
        rd_s = hrdata;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            finish_test();
        end
    end
    // ****
    // shared tasks
    // ****
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test
    task automatic check(input logic [31:0] exp, input logic [31:0] got, input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clk);
        while (rdy_s !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (rdy_s !== 1'b1) @(posedge clk);
        q = rd_s;
    endtask : bus
    task automatic rchk(input logic [31:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0);
        check(exp, q, what);
        check(32'h0, {31'h0, hresp}, "hresp okay");
    endtask : rchk
    task automatic src(input logic [2:0] i, input logic [15:0] v);
        set_idx <= i;
        set_val <= v;
        set_stb <= 1'b1;
        @(posedge clk);
        set_stb <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : src
    function automatic logic [31:0] ta(input int t, input int off);
        return 32'(256 * (t + 1) + off);
    endfunction : ta
    // x axis written top index first so the ordering clamp never bites
    task automatic xaxis(input int t, input logic [31:0] hi, input logic [31:0] x1);
        for (int n = 10; n >= 2; n--) bus(1'b1, ta(t, 'h40 + 4 * n), hi);
        bus(1'b1, ta(t, 'h44), x1);
    endtask : xaxis
    // ****
    // scenarios
    // ****
    task automatic t_reset();
        check(32'h0, {15'h0, sel_active, sel_out}, "reset outputs");
        check(32'h0, table_out[31:0], "reset tables");
        rchk(32'h0, 32'h0, "ctrl");
        bus(1'b1, ta(0, 'h80), 32'h0001_0000);
        rchk(ta(0, 'h80), 32'h0002_0000, "point0 type");
        rchk(ta(0, 'h84), 32'h0, "point1 type");
        rchk(32'h0000_1000, 32'h0, "unmapped");
        // table two takes source 7, which brings its own span of -100..500
        bus(1'b1, ta(1, 0), 32'h70);
        bus(1'b1, ta(1, 'h68), 32'h7D0);
        rchk(ta(1, 'h68), 32'h1F4, "x10 source max");
        bus(1'b1, ta(1, 'h40), 32'hFF38);
        rchk(ta(1, 'h40), 32'hFFFF_FF9C, "x0 source min");
    endtask : t_reset
    task automatic t_lookup();
        bus(1'b1, ta(0, 'h68), 32'h7D0);
        rchk(ta(0, 'h68), 32'h3E8, "x10 clamp");
        xaxis(0, 32'hC8, 32'h64);
        bus(1'b1, ta(0, 'h84), 32'h0001_03E8);
        bus(1'b1, ta(0, 'h88), 32'h0002_0032);
        src(3'h0, 16'h0032);
        check(32'h1F4, {16'h0, table_out[15:0]}, "ramp");
        src(3'h0, 16'h0096);
        check(32'h32, {16'h0, table_out[15:0]}, "jump");
        src(3'h0, 16'h012C);
        check(32'h32, {16'h0, table_out[15:0]}, "past last");
        src(3'h0, 16'h0000);
        check(32'h0, {16'h0, table_out[15:0]}, "at x0");
        rchk(ta(0, 'h08), 32'h03E8_0000, "y range");
        bus(1'b1, ta(0, 'h44), 32'h12C);
        rchk(ta(0, 'h44), 32'hC8, "x order");
        bus(1'b1, ta(0, 'h44), 32'h64);
        src(3'h0, 16'h0032);
    endtask : t_lookup
    task automatic t_select();
        logic [5:0] op_true;
        logic [4:0] cmb_true;
        op_true = 6'b001110;
        cmb_true = 5'b00101;
        bus(1'b1, ta(1, 'h80), 32'h4D);
        bus(1'b1, 32'h0, 32'h1);
        bus(1'b1, 32'h20, 32'h2);
        for (int op = 0; op < 6; op++) begin
            bus(1'b1, 32'h10, 32'h11);
            bus(1'b1, 32'h14, 32'h10 | 32'(op));
            repeat (3) @(posedge clk);
            rchk(32'h4, op_true[op] ? 32'h0 : 32'h1, "entry by op");
            check(op_true[op] ? 32'h1F4 : 32'h4D, {16'h0, sel_out}, "sel out");
        end
        check(32'h4D, {16'h0, table_out[31:16]}, "table two out");
        bus(1'b1, 32'h14, 32'h10);
        bus(1'b1, 32'h1C, 32'h1);
        for (int c = 0; c < 5; c++) begin
            bus(1'b1, 32'h10, 32'h1 | 32'(c << 4));
            repeat (3) @(posedge clk);
            rchk(32'h4, cmb_true[c] ? 32'h0 : 32'h1, "entry by combine");
        end
        bus(1'b1, 32'h24, 32'h1);
        bus(1'b1, 32'h20, 32'h12);
        bus(1'b1, 32'h34, 32'h1);
        bus(1'b1, 32'h30, 32'h13);
        repeat (3) @(posedge clk);
        rchk(32'h4, 32'h0, "fallback entry");
        check(32'h1F4, {16'h0, sel_out}, "fallback out");
        bus(1'b1, 32'h0, 32'h0);
        repeat (3) @(posedge clk);
        check(32'h0, {15'h0, sel_active, sel_out}, "disabled");
    endtask : t_select
    task automatic t_time();
        logic low_seen;
        low_seen = 1'b0;
        bus(1'b1, ta(2, 0), 32'h21);
        xaxis(2, 32'h5, 32'h5);
        bus(1'b1, ta(2, 'h84), 32'h0001_0032);
        repeat (3) @(posedge clk);
        check(32'h0, {16'h0, table_out[47:32]}, "time idle");
        src(3'h2, 16'h0001);
        repeat (80) @(posedge clk);
        check(32'h32, {16'h0, table_out[47:32]}, "time end held");
        bus(1'b1, ta(2, 0), 32'h23);
        repeat (80) begin
            @(posedge clk);
            if (table_out[47:32] !== 16'h0032) low_seen = 1'b1;
        end
        check(32'h1, {31'h0, low_seen}, "autocycle wrap");
        src(3'h2, 16'h0000);
        check(32'h0, {16'h0, table_out[47:32]}, "time stop");
    endtask : t_time
    initial begin
        sys_rst = 1'b1;
        {hsel, hwrite, set_stb} = '0;
        {haddr, hwdata, htrans, set_idx, set_val} = '0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_lookup();
        t_select();
        t_time();
        finish_test();
    end
endmodule : tb_lookup_table_logic_selector
